/* File: bench/fio_host.sv */
`timescale 1ns/100ps

// Maintenance host as a bus master; it leaves one idle cycle between transfers.
module fio_host (
  // Clock and bus.
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel = 1'b1,
  output logic [31:0]      haddr = 32'h0,
  output logic [1:0]       htrans = 2'h0,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'h2,
  output logic [31:0]      hwdata = 32'h0
);
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task cmd(input int pos);
    logic [31:0] q;
    xfer(1'b1, fio_pkg::ADDR_CTRL, 32'h1 << pos, q);
  endtask : cmd

  // The release-all command drops every designation in a single host write.
  task rel_all;
    cmd(fio_pkg::CTRL_RELALL_POS);
  endtask : rel_all
endmodule : fio_host

/* File: bench/fio_override_asserts.sv */
`timescale 1ns/100ps

module fio_override_chk #(
  parameter int N_IN         = 8,
  parameter int N_OUT        = 8,
  parameter int RESET_IN_POS = 0
) (
  // Clock, reset and events.
  input wire logic             clk_sys,
  input wire logic             rstn,
  input wire logic             power_up_evt,
  input wire logic             download_evt,
  input wire logic             download_suspend,
  input wire logic             firmware_reload_evt,
  input wire logic             plc_running,
  // Points and indicators.
  input wire logic [N_IN-1:0]  in_to_program,
  input wire logic [N_IN-1:0]  in_raw_special,
  input wire logic [N_OUT-1:0] out_from_program,
  input wire logic [N_OUT-1:0] out_pin,
  input wire logic             reset_input_active,
  input wire logic             err_led,
  input wire logic             run_led
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_run; run_led == plc_running; endproperty
  a_run: assert property (p_run) else $error("run led wrong");
  property p_susp; !err_led |-> in_to_program == in_raw_special; endproperty
  a_susp: assert property (p_susp) else $error("input overridden");
  property p_out; $past(rstn) && !$past(err_led) |-> out_pin == $past(out_from_program);
  endproperty
  a_out: assert property (p_out) else $error("output overridden");
  // The designations drop at the very edge that first sees the reset input high.
  property p_clr; $rose(reset_input_active) && err_led |=> in_to_program == in_raw_special;
  endproperty
  a_clr: assert property (p_clr) else $error("reset input kept forces");
  property p_fw; firmware_reload_evt |-> ##[1:2] in_to_program == in_raw_special; endproperty
  a_fw: assert property (p_fw) else $error("reload kept forces");
  property p_pwr; power_up_evt |=> !err_led; endproperty
  a_pwr: assert property (p_pwr) else $error("power-up left forcing on");
  property p_dl; download_evt && download_suspend |=> !err_led; endproperty
  a_dl: assert property (p_dl) else $error("download kept forcing on");
  property p_stop; $changed(plc_running) |=> $stable(err_led); endproperty
  a_stop: assert property (p_stop) else $error("run change moved forcing");
  cover property (err_led && !plc_running);
  cover property ($rose(reset_input_active));
  cover property (download_evt && !download_suspend);
endmodule : fio_override_chk

bind fio_override fio_override_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .RESET_IN_POS(RESET_IN_POS))
  chk_u (.clk_sys(clk_sys), .rstn(rstn), .power_up_evt(power_up_evt),
  .download_evt(download_evt), .download_suspend(download_suspend),
  .firmware_reload_evt(firmware_reload_evt), .plc_running(plc_running),
  .in_to_program(in_to_program), .in_raw_special(in_raw_special),
  .out_from_program(out_from_program), .out_pin(out_pin),
  .reset_input_active(reset_input_active), .err_led(err_led), .run_led(run_led));

/* File: bench/tb_top.sv */
`timescale 1ns/100ps

module tb_top;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, bat, dls, run, mnt, rst_act, err_led, run_led;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ev;
  logic [7:0]  in_pin, in_prog, raw, out_prog, out_pin;
  int          failures = 0;
  int          check_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  fio_host host_u (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  fio_override #(.N_IN(8), .N_OUT(8)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .power_up_evt(ev[0]), .battery_lost(bat), .download_evt(ev[1]), .download_suspend(dls),
    .firmware_reload_evt(ev[2]), .plc_running(run), .maintain_outputs_on_stop_flag(mnt),
    .in_pin(in_pin), .in_to_program(in_prog), .in_raw_special(raw),
    .out_from_program(out_prog), .out_pin(out_pin), .reset_input_active(rst_act),
    .err_led(err_led), .run_led(run_led));

  task wrap_up;
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host_u.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rc

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask : wr

  task pulse(input int k);
    @(posedge clk_sys);
    ev <= 3'h1 << k;
    @(posedge clk_sys);
    ev <= 3'h0;
  endtask : pulse

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  // Pin bit 0 carries the reset-input function and stays low until the last scenario.
  initial
  begin
    ev <= 3'h0;
    {bat, dls, run, mnt} <= 4'h0;
    in_pin <= 8'ha4;
    out_prog <= 8'h3c;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rc(fio_pkg::ADDR_STATUS, 32'h0);
    rc(8'h40, 32'h0);
    run <= 1'b1;
    wr(fio_pkg::ADDR_IN_DESIG, 32'h0c);
    wr(fio_pkg::ADDR_IN_VAL, 32'h08);
    wr(fio_pkg::ADDR_OUT_DESIG, 32'h81);
    wr(fio_pkg::ADDR_OUT_VAL, 32'h01);
    rc(fio_pkg::ADDR_IN_SEEN, 32'ha4);
    host_u.cmd(fio_pkg::CTRL_TOGGLE_POS);
    repeat (2) @(posedge clk_sys);
    chk({24'h0, in_prog}, 32'ha8);
    chk({24'h0, out_pin}, 32'h3d);
    chk({24'h0, raw}, 32'ha4);
    chk({30'h0, run_led, err_led}, 32'h3);
    rc(fio_pkg::ADDR_STATUS, 32'h3);
    run <= 1'b0;
    mnt <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({16'h0, in_prog, out_pin}, 32'ha83d);
    wr(fio_pkg::ADDR_IN_DESIG, 32'h04);
    wr(fio_pkg::ADDR_OUT_DESIG, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({16'h0, in_prog, out_pin}, 32'ha03c);
    rc(fio_pkg::ADDR_IN_DESIG, 32'h04);
    pulse(1);
    rc(fio_pkg::ADDR_STATUS, 32'h1);
    dls <= 1'b1;
    pulse(1);
    rc(fio_pkg::ADDR_STATUS, 32'h0);
    rc(fio_pkg::ADDR_IN_DESIG, 32'h04);
    host_u.cmd(fio_pkg::CTRL_TOGGLE_POS);
    pulse(0);
    rc(fio_pkg::ADDR_STATUS, 32'h0);
    rc(fio_pkg::ADDR_IN_DESIG, 32'h04);
    bat <= 1'b1;
    pulse(0);
    rc(fio_pkg::ADDR_IN_DESIG, 32'h0);
    host_u.cmd(fio_pkg::CTRL_TOGGLE_POS);
    for (int k = 0; k < 4; k++)
    begin
      wr(fio_pkg::ADDR_OUT_DESIG, 32'h81);
      wr(fio_pkg::ADDR_IN_VAL, (k == 3) ? 32'h09 : 32'h08);
      wr(fio_pkg::ADDR_IN_DESIG, (k == 3) ? 32'h0d : 32'h0c);
      if (k == 0)
        host_u.rel_all();
      else if (k == 1)
        host_u.cmd(fio_pkg::CTRL_CLRALL_POS);
      else if (k == 2)
        pulse(2);
      repeat (4) @(posedge clk_sys);
      rc(fio_pkg::ADDR_IN_DESIG, 32'h0);
      rc(fio_pkg::ADDR_OUT_DESIG, 32'h0);
      chk({24'h0, in_prog}, 32'ha4);
    end
    rc(fio_pkg::ADDR_STATUS, 32'h1);
    host_u.cmd(fio_pkg::CTRL_SUSPEND_POS);
    rc(fio_pkg::ADDR_STATUS, 32'h0);
    host_u.cmd(fio_pkg::CTRL_TOGGLE_POS);
    wr(fio_pkg::ADDR_OUT_DESIG, 32'h81);
    rc(fio_pkg::ADDR_OUT_SEEN, 32'h3d);
    in_pin <= 8'ha5;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, rst_act}, 32'h1);
    rc(fio_pkg::ADDR_STATUS, 32'h5);
    rc(fio_pkg::ADDR_OUT_DESIG, 32'h0);
    rc(fio_pkg::ADDR_OUT_SEEN, 32'h3c);
    rc(fio_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wrap_up();
  end
endmodule : tb_top

/* File: core/fio_override.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// How it works
// - An input point that is designated while forcing is active shows its forced value to the program.
// - An output point that is designated while forcing is active drives its forced value to the pin.
// - Every input and every output point has its own designation bit and forced value bit.
// - Designations and forcing survive run and stop, whatever the maintain-outputs-on-stop flag says.
// - At power-up designations are kept but forcing comes up suspended.
// - At power-up with a lost backup battery all designations are cleared.
// - A program download keeps designations and suspends forcing only if the host asks for it.
// - The reset input, a clear-all-devices command or a firmware reload clears all designations.
// - Counter, catch and interrupt inputs always see the physical pin levels.
// - Once the reset input becomes active, even through a force, all designations are cleared.
// - One host command toggles forcing between active and suspended without touching designations.
// - A designation stays stored until the host releases that point or one of the clearing events above occurs.
// - A released point follows its physical input or program output again.
// - The forcing state is reported to the host and on the error LED, never on the run LED.
module fio_override #(
  parameter int N_IN         = 32,
  parameter int N_OUT        = 32,
  parameter int RESET_IN_POS = fio_pkg::RESET_IN_POS_DEF
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // AHB-Lite slave.
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Controller events.
  input  wire logic              power_up_evt,
  input  wire logic              battery_lost,
  input  wire logic              download_evt,
  input  wire logic              download_suspend,
  input  wire logic              firmware_reload_evt,
  input  wire logic              plc_running,
  input  wire logic              maintain_outputs_on_stop_flag,
  // Physical inputs and program-facing values.
  input  wire logic [N_IN-1:0]   in_pin,
  output logic      [N_IN-1:0]   in_to_program,
  output logic      [N_IN-1:0]   in_raw_special,
  // Program outputs and physical outputs.
  input  wire logic [N_OUT-1:0]  out_from_program,
  output logic      [N_OUT-1:0]  out_pin,
  // Indicators.
  output logic                   reset_input_active,
  output logic                   err_led,
  output logic                   run_led
);

  logic [N_IN-1:0]  in_sync;
  logic [N_IN-1:0]  in_desig_ff;
  logic [N_IN-1:0]  in_val_ff;
  logic [N_OUT-1:0] out_desig_ff;
  logic [N_OUT-1:0] out_val_ff;
  logic             active_ff;
  logic             rst_in_prev_ff;
  logic             ph_wr_ff;
  logic             ph_rd_ff;
  logic [7:0]       ph_addr_ff;
  logic [31:0]      rdata_ff;
  logic [N_OUT-1:0] out_pin_ff;

  fio_sync #(
    .WIDTH (N_IN)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_in   (in_pin),
    .pin_sync (in_sync)
  );

  // Address phase capture; the slave never inserts wait states.
  wire addr_ok  = hsel && hready && htrans[1];
  wire wr_take  = addr_ok && hwrite;
  wire rd_take  = addr_ok && !hwrite;

  wire wr_ctrl      = ph_wr_ff && (ph_addr_ff == fio_pkg::ADDR_CTRL);
  wire wr_in_desig  = ph_wr_ff && (ph_addr_ff == fio_pkg::ADDR_IN_DESIG);
  wire wr_in_val    = ph_wr_ff && (ph_addr_ff == fio_pkg::ADDR_IN_VAL);
  wire wr_out_desig = ph_wr_ff && (ph_addr_ff == fio_pkg::ADDR_OUT_DESIG);
  wire wr_out_val   = ph_wr_ff && (ph_addr_ff == fio_pkg::ADDR_OUT_VAL);

  wire cmd_toggle  = wr_ctrl && hwdata[fio_pkg::CTRL_TOGGLE_POS];
  wire cmd_relall  = wr_ctrl && hwdata[fio_pkg::CTRL_RELALL_POS];
  wire cmd_clrall  = wr_ctrl && hwdata[fio_pkg::CTRL_CLRALL_POS];
  wire cmd_suspend = wr_ctrl && hwdata[fio_pkg::CTRL_SUSPEND_POS];

  // one select per point; suspended forcing leaves every point on its normal value.
  wire [N_OUT-1:0] nxt_out_pin;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_in_sel
      wire in_forced = active_ff && in_desig_ff[gi];

      assign in_to_program[gi] = in_forced ? in_val_ff[gi] : in_sync[gi];
    end
    for (gi = 0; gi < N_OUT; gi++)
    begin : g_out_sel
      wire out_forced = active_ff && out_desig_ff[gi];

      assign nxt_out_pin[gi] = out_forced ? out_val_ff[gi] : out_from_program[gi];
    end
  endgenerate

  // Counter, catch and interrupt logic bypasses the select, so a force never reaches it.
  assign in_raw_special = in_sync;

  // The reset-input function is read from the forced view, so a forced reset counts too.
  assign reset_input_active = in_to_program[RESET_IN_POS];
  wire rst_in_rise = reset_input_active && !rst_in_prev_ff;

  // Designations are cleared on any of these; run, stop and the stop flag play no part.
  wire clear_all = rst_in_rise || cmd_clrall || cmd_relall || firmware_reload_evt
                 || (power_up_evt && battery_lost);

  wire suspend_evt = power_up_evt || (download_evt && download_suspend) || cmd_suspend;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ph_wr_ff   <= 1'b0;
      ph_rd_ff   <= 1'b0;
      ph_addr_ff <= 8'h00;
    end
    else
    begin
      ph_wr_ff   <= wr_take;
      ph_rd_ff   <= rd_take;
      ph_addr_ff <= haddr[7:0];
    end
  end

  // one designation and one value bit per point, written by the host as words.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      in_desig_ff  <= '0;
      out_desig_ff <= '0;
    end
    else if (clear_all)
    begin
      in_desig_ff  <= '0;
      out_desig_ff <= '0;
    end
    else
    begin
      if (wr_in_desig)
        in_desig_ff <= hwdata[N_IN-1:0];
      if (wr_out_desig)
        out_desig_ff <= hwdata[N_OUT-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      in_val_ff  <= '0;
      out_val_ff <= '0;
    end
    else
    begin
      if (wr_in_val)
        in_val_ff <= hwdata[N_IN-1:0];
      if (wr_out_val)
        out_val_ff <= hwdata[N_OUT-1:0];
    end
  end

  // Suspension wins over a toggle arriving in the same cycle, the safer outcome.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      active_ff <= fio_pkg::RST_ACTIVE;
    else if (suspend_evt)
      active_ff <= 1'b0;
    else if (cmd_toggle)
      active_ff <= !active_ff;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rst_in_prev_ff <= 1'b0;
      out_pin_ff     <= '0;
    end
    else
    begin
      rst_in_prev_ff <= reset_input_active;
      out_pin_ff     <= nxt_out_pin;
    end
  end

  // The output stage adds one flop so the pins never glitch during a select change.
  assign out_pin = out_pin_ff;

  // Read data is registered in the address phase and presented in the data phase.
  logic [31:0] status_word;

  always_comb
  begin
    status_word                          = 32'h00000000;
    status_word[fio_pkg::STAT_ACTIVE_POS] = active_ff;
    status_word[fio_pkg::STAT_RUN_POS]    = plc_running;
    status_word[fio_pkg::STAT_RESET_POS]  = reset_input_active;
  end

  wire [7:0]  rd_addr       = haddr[7:0];
  wire        sel_status    = (rd_addr == fio_pkg::ADDR_STATUS);
  wire        sel_in_desig  = (rd_addr == fio_pkg::ADDR_IN_DESIG);
  wire        sel_in_val    = (rd_addr == fio_pkg::ADDR_IN_VAL);
  wire        sel_out_desig = (rd_addr == fio_pkg::ADDR_OUT_DESIG);
  wire        sel_out_val   = (rd_addr == fio_pkg::ADDR_OUT_VAL);
  wire        sel_in_seen   = (rd_addr == fio_pkg::ADDR_IN_SEEN);
  wire        sel_out_seen  = (rd_addr == fio_pkg::ADDR_OUT_SEEN);
  logic [31:0] rd_mux;

  // The control word reads as zero: its bits are commands that last a single cycle.
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (sel_status)
      rd_mux = status_word;
    else if (sel_in_desig)
      rd_mux = 32'(in_desig_ff);
    else if (sel_in_val)
      rd_mux = 32'(in_val_ff);
    else if (sel_out_desig)
      rd_mux = 32'(out_desig_ff);
    else if (sel_out_val)
      rd_mux = 32'(out_val_ff);
    else if (sel_in_seen)
      rd_mux = 32'(in_to_program);
    else if (sel_out_seen)
      rd_mux = 32'(out_pin_ff);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rdata_ff <= 32'h00000000;
    else if (rd_take)
      rdata_ff <= rd_mux;
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // forcing state on the error indicator only; run LED follows run state alone.
  assign err_led = active_ff;
  assign run_led = plc_running;

  wire unused_ok = &{1'b0, hsize, ph_rd_ff, maintain_outputs_on_stop_flag, hwdata[31:4]};

endmodule : fio_override

/* File: core/fio_pkg.sv */
package fio_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IN_DESIG = 8'h08;
  localparam logic [7:0] ADDR_IN_VAL   = 8'h0c;
  localparam logic [7:0] ADDR_OUT_DESIG = 8'h10;
  localparam logic [7:0] ADDR_OUT_VAL  = 8'h14;
  localparam logic [7:0] ADDR_IN_SEEN  = 8'h18;
  localparam logic [7:0] ADDR_OUT_SEEN = 8'h1c;

  // Control register bit positions; every control bit is a self-clearing command.
  localparam int CTRL_TOGGLE_POS  = 0;
  localparam int CTRL_RELALL_POS  = 1;
  localparam int CTRL_CLRALL_POS  = 2;
  localparam int CTRL_SUSPEND_POS = 3;

  // Status register bit positions.
  localparam int STAT_ACTIVE_POS = 0;
  localparam int STAT_RUN_POS    = 1;
  localparam int STAT_RESET_POS  = 2;

  // Value after reset of the forcing state.
  localparam logic RST_ACTIVE = 1'b0;

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 3;

  // Bit position of the input that carries the reset-input function.
  localparam int RESET_IN_POS_DEF = 0;

endpackage : fio_pkg

/* File: core/fio_sync.sv */
`timescale 1ns/100ps

// Three-flop pin synchroniser per bit; a change is accepted when stages two and three agree.
module fio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Pins and filtered result.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic [fio_pkg::SYNC_STAGES-1:0] stage_ff;
      logic                            level_ff;
      wire                             agree = (stage_ff[1] == stage_ff[2]);

      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
        begin
          stage_ff <= '0;
          level_ff <= 1'b0;
        end
        else
        begin
          stage_ff <= {stage_ff[1:0], pin_in[g]};
          if (agree)
            level_ff <= stage_ff[2];
        end
      end

      assign pin_sync[g] = level_ff;
    end
  endgenerate

endmodule : fio_sync
